/* File: hdl/mode_select_pkg.sv */
// Purpose: shared constants, types and state layouts for mode select and self-check
// Assumes: 8-bit register port, 16-bit CPU addresses
// Notes: register offsets are byte addresses on the plain register port
package mode_select_pkg;

  // register offsets, misc control reset value and read-back zero
  localparam logic [7:0] MISC_CONTROL_ADDR = 8'h0C;
  localparam logic [7:0] MODE_STATUS_ADDR = 8'h0D;
  localparam logic [7:0] CHECK_REPORT_ADDR = 8'h0E;
  localparam logic [7:0] BOOT_DATA_ADDR = 8'h0F;
  localparam logic [7:0] MISC_CONTROL_RESET = 8'h10;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // field positions
  localparam int unsigned LOW_VOLTAGE_ENABLE_BIT = 3;
  localparam int unsigned REPORT_PASS_BIT = 7;
  localparam int unsigned REPORT_FAIL_BIT = 6;

  // memory map of the resident programs and the user EPROM
  localparam logic [15:0] SELFCHECK_START = 16'h1F00;
  localparam logic [15:0] SELFCHECK_END = 16'h1FEF;
  localparam logic [15:0] EPROM_START = 16'h1000;
  localparam logic [15:0] EPROM_END = 16'h1EFF;
  localparam logic [15:0] EPROM_BYTES = 16'h0F00;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  // pin synchroniser lanes
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned PIN_TST = 0;
  localparam int unsigned PIN_STRAP = 1;
  localparam int unsigned PIN_LOW = 2;
  localparam int unsigned PIN_VARIANT = 3;

  // led codes, led 4 down to led 1, one is lit
  localparam logic [3:0] LED_OFF = 4'h0;
  localparam logic [3:0] LED_ALL = 4'hF;
  localparam logic [3:0] LED_BAD_PORT_A = 4'hF;
  localparam logic [3:0] LED_BAD_PORT_B = 4'hE;
  localparam logic [3:0] LED_BAD_PORT_C = 4'hD;
  localparam logic [3:0] LED_BAD_PORT_D = 4'hC;
  localparam logic [3:0] LED_BAD_RAM = 4'hB;
  localparam logic [3:0] LED_BAD_ROM = 4'hA;
  localparam logic [3:0] LED_BAD_SOFT_INT = 4'h8;
  localparam logic [3:0] LED_BAD_IRQ = 4'h7;

  typedef enum logic [1:0] {
    MODE_USER = 2'b00,
    MODE_SELFCHECK = 2'b01,
    MODE_BOOTSTRAP = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN = 2'b01,
    CHK_FAIL = 2'b10
  } check_state_t;

  typedef enum logic [2:0] {
    FAIL_PORT_A = 3'b000,
    FAIL_PORT_B = 3'b001,
    FAIL_PORT_C = 3'b010,
    FAIL_PORT_D = 3'b011,
    FAIL_RAM = 3'b100,
    FAIL_ROM = 3'b101,
    FAIL_SOFTWARE_INTERRUPT = 3'b110,
    FAIL_EXT_INTERRUPT = 3'b111
  } fail_kind_t;

  typedef struct packed {
    logic status_led_4;
    logic status_led_3;
    logic status_led_2;
    logic status_led_1;
  } status_leds_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic mode_valid;
    op_mode_t mode;
    logic [7:0] misc;
    check_state_t chk;
    logic [3:0] leds;
    logic [7:0] rdata;
    logic [15:0] start_addr;
    logic lvr_reset;
    logic retention;
  } top_state_t;

  typedef struct packed {
    logic [15:0] next_addr;
    logic [15:0] out_addr;
    logic [7:0] data;
    logic we;
    logic done;
  } prog_state_t;

  localparam top_state_t TOP_STATE_RESET = '{
    sync1: '0, sync2: '0, mode_valid: 1'b0, mode: MODE_USER,
    misc: MISC_CONTROL_RESET, chk: CHK_IDLE, leds: LED_OFF,
    rdata: READ_ZERO, start_addr: '0, lvr_reset: 1'b0, retention: 1'b0
  };

  localparam prog_state_t PROG_STATE_RESET = '{
    next_addr: EPROM_START, out_addr: EPROM_START, data: '0,
    we: 1'b0, done: 1'b0
  };

endpackage : mode_select_pkg

/* File: hdl/eprom_prog_seq.sv */
// Purpose: steps bootstrap data bytes through the user EPROM address range
// Assumes: one data byte per accepted write, addresses ascending
// Notes: writes after the last location are ignored until the next reset
`timescale 1ns/10ps
`default_nettype none
module eprom_prog_seq (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic enable,
  input wire logic data_wr,
  input wire logic [7:0] data_in,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  output logic prog_we,
  output logic prog_done
);
  import mode_select_pkg::*;

  prog_state_t s_q;
  prog_state_t s_d;

  // accept one byte per write, walking from the first to the last EPROM cell
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    if (enable && data_wr && !s_q.done) begin
      s_d.out_addr = s_q.next_addr;
      s_d.data = data_in;
      s_d.we = 1'b1;
      if (s_q.next_addr == EPROM_END) begin
        s_d.done = 1'b1;
      end else begin
        s_d.next_addr = s_q.next_addr + ADDR_STEP;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= PROG_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state register
  assign prog_addr = s_q.out_addr;
  assign prog_data = s_q.data;
  assign prog_we = s_q.we;
  assign prog_done = s_q.done;

endmodule : eprom_prog_seq
`default_nettype wire

/* File: hdl/mode_select_selfcheck.sv */
// Purpose: operating mode selection at reset release, self-check led report,
//   bootstrap programming hand-off and low-voltage reset control
// Assumes: strap and supply pins are asynchronous and pass two flops first
// Notes: self-check and bootstrap software drives progress through registers
//
// Notes on behaviour
// - misc control bit 3 set enables low-voltage reset, clear disables it.
// - with low-voltage reset off, low supply keeps RAM and register contents.
// - normal levels on both strap pins at reset release select user mode.
// - test level plus strap high at reset release select self-check mode.
// - self-check mode starts the CPU at the resident program at 1F00-1FEF.
// - once self-check or bootstrap is chosen, the strap pin is a port again.
// - self-check repeats forever while every test passes.
// - passing self-check toggles the port A leds so they flash.
// - port failures show steady codes 1111, 1110, 1101, 1100 for A to D.
// - RAM, ROM, software and external interrupt failures show 1011 1010 1000 0111.
// - on the EPROM variant the same strap levels select bootstrap mode.
// - bootstrap mode starts the CPU at the resident bootstrap program.
// - bootstrap programs the 3840-byte user EPROM from 1000 to 1EFF.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module mode_select_selfcheck #(
  parameter logic [15:0] USER_START = 16'h0000,
  parameter logic [15:0] BOOT_START = 16'h1F00
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic test_voltage_level,
  input wire logic mode_strap_pin,
  input wire logic supply_low,
  input wire logic eprom_variant,
  input wire mode_select_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output mode_select_pkg::status_leds_t status_leds,
  output mode_select_pkg::op_mode_t op_mode,
  output logic mode_valid,
  output logic strap_released,
  output logic [15:0] cpu_start_addr,
  output logic low_voltage_reset_enable,
  output logic low_voltage_reset,
  output logic retention_hold,
  output logic [15:0] eprom_addr,
  output logic [7:0] eprom_data,
  output logic eprom_we,
  output logic eprom_done
);
  import mode_select_pkg::*;

  top_state_t s_q;
  top_state_t s_d;
  logic [PIN_COUNT-1:0] pins_raw;
  logic boot_wr;
  logic boot_enable;
  logic test_sel;
  logic supply_low_s;

  // maps a reported failure to its steady led code
  function automatic logic [3:0] fail_code(input fail_kind_t kind);
    logic [3:0] code;
    code = LED_BAD_PORT_A;
    case (kind)
      FAIL_PORT_A: code = LED_BAD_PORT_A;
      FAIL_PORT_B: code = LED_BAD_PORT_B;
      FAIL_PORT_C: code = LED_BAD_PORT_C;
      FAIL_PORT_D: code = LED_BAD_PORT_D;
      FAIL_RAM: code = LED_BAD_RAM;
      FAIL_ROM: code = LED_BAD_ROM;
      FAIL_SOFTWARE_INTERRUPT: code = LED_BAD_SOFT_INT;
      FAIL_EXT_INTERRUPT: code = LED_BAD_IRQ;
      default: code = LED_BAD_PORT_A;
    endcase
    return code;
  endfunction : fail_code

  // gather the asynchronous pins into one synchroniser vector
  always_comb begin
    pins_raw = '0;
    pins_raw[PIN_TST] = test_voltage_level;
    pins_raw[PIN_STRAP] = mode_strap_pin;
    pins_raw[PIN_LOW] = supply_low;
    pins_raw[PIN_VARIANT] = eprom_variant;
  end

  // only the second synchroniser stage feeds logic
  assign test_sel = s_q.sync2[PIN_TST] && s_q.sync2[PIN_STRAP];
  assign supply_low_s = s_q.sync2[PIN_LOW];

  // bootstrap data writes go to the programming sequencer
  assign boot_enable = s_q.mode_valid && (s_q.mode == MODE_BOOTSTRAP);
  assign boot_wr = reg_req.wr && (reg_req.addr == BOOT_DATA_ADDR) && !s_q.retention;

  // next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pins_raw;
    s_d.sync2 = s_q.sync1;
    s_d.rdata = READ_ZERO;

    // low supply: reset request only when enabled, else hold contents
    s_d.lvr_reset = s_q.misc[LOW_VOLTAGE_ENABLE_BIT] && supply_low_s;
    s_d.retention = !s_q.misc[LOW_VOLTAGE_ENABLE_BIT] && supply_low_s;

    // mode capture on the first cycle after reset release, then frozen
    if (!s_q.mode_valid) begin
      s_d.mode_valid = 1'b1;
      if (test_sel && s_q.sync2[PIN_VARIANT]) begin
        s_d.mode = MODE_BOOTSTRAP;
        s_d.start_addr = BOOT_START;
        s_d.chk = CHK_IDLE;
      end else if (test_sel) begin
        s_d.mode = MODE_SELFCHECK;
        s_d.start_addr = SELFCHECK_START;
        s_d.chk = CHK_RUN;
        s_d.leds = LED_OFF;
      end else begin
        s_d.mode = MODE_USER;
        s_d.start_addr = USER_START;
        s_d.chk = CHK_IDLE;
      end
    end

    // register writes and self-check progress are frozen in retention
    if (!s_q.retention) begin
      if (reg_req.wr) begin
        if (reg_req.addr == MISC_CONTROL_ADDR) begin
          s_d.misc = reg_req.wdata;
        end else if (reg_req.addr == CHECK_REPORT_ADDR) begin
          case (s_q.chk)
            CHK_RUN: begin
              if (reg_req.wdata[REPORT_FAIL_BIT]) begin
                s_d.chk = CHK_FAIL;
                s_d.leds = fail_code(fail_kind_t'(reg_req.wdata[2:0]));
              end else if (reg_req.wdata[REPORT_PASS_BIT]) begin
                s_d.chk = CHK_RUN;
                s_d.leds = ~s_q.leds;
              end
            end
            CHK_FAIL: begin
              s_d.chk = CHK_FAIL; // steady code stays until reset
            end
            default: begin
              s_d.chk = s_q.chk;
            end
          endcase
        end
      end
    end

    // read data stands only in the cycle after the read strobe
    if (reg_req.rd) begin
      if (reg_req.addr == MISC_CONTROL_ADDR) begin
        s_d.rdata = s_q.misc;
      end else if (reg_req.addr == MODE_STATUS_ADDR) begin
        s_d.rdata = {3'h0, s_q.retention, s_q.misc[LOW_VOLTAGE_ENABLE_BIT], s_q.mode_valid,
          s_q.mode};
      end else if (reg_req.addr == CHECK_REPORT_ADDR) begin
        s_d.rdata = {2'h0, s_q.chk, s_q.leds};
      end else if (reg_req.addr == BOOT_DATA_ADDR) begin
        s_d.rdata = {7'h00, eprom_done};
      end else begin
        s_d.rdata = READ_ZERO;
      end
    end
  end

  // state register; synchronisers keep running through reset so the
  // strap levels present while reset is low are seen at release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= TOP_STATE_RESET;
      s_q.sync1 <= s_d.sync1;
      s_q.sync2 <= s_d.sync2;
    end else begin
      s_q <= s_d;
    end
  end

  // bootstrap programming of the user EPROM
  eprom_prog_seq u_prog (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(boot_enable),
    .data_wr(boot_wr),
    .data_in(reg_req.wdata),
    .prog_addr(eprom_addr),
    .prog_data(eprom_data),
    .prog_we(eprom_we),
    .prog_done(eprom_done)
  );

  // outputs straight from state flops
  assign reg_rdata = s_q.rdata;
  assign status_leds = status_leds_t'(s_q.leds);
  assign op_mode = s_q.mode;
  assign mode_valid = s_q.mode_valid;
  assign strap_released = s_q.mode_valid;
  assign cpu_start_addr = s_q.start_addr;
  assign low_voltage_reset_enable = s_q.misc[LOW_VOLTAGE_ENABLE_BIT];
  assign low_voltage_reset = s_q.lvr_reset;
  assign retention_hold = s_q.retention;

endmodule : mode_select_selfcheck
`default_nettype wire

/* File: bench/mode_select_props.sv */
// Purpose: concurrent checks on the mode select and self-check ports
// Assumes: strap and supply pins stay steady around every reset release
// Notes: bound onto the top module and reads only its ports
`timescale 1ns/10ps
`default_nettype none
module mode_select_props #(
  parameter logic [15:0] USER_START = 16'h0000,
  parameter logic [15:0] BOOT_START = 16'h1F00
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic test_voltage_level,
  input wire logic mode_strap_pin,
  input wire logic supply_low,
  input wire logic eprom_variant,
  input wire mode_select_pkg::status_leds_t status_leds,
  input wire mode_select_pkg::op_mode_t op_mode,
  input wire logic mode_valid,
  input wire logic strap_released,
  input wire logic [15:0] cpu_start_addr,
  input wire logic low_voltage_reset_enable,
  input wire logic low_voltage_reset,
  input wire logic retention_hold,
  input wire logic [15:0] eprom_addr,
  input wire logic eprom_we,
  input wire logic eprom_done
);
  import mode_select_pkg::*;
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // pins pass two sync flops before the latch, hence a depth of three
  a_mode_pick: assert property ($rose(mode_valid) |-> op_mode ==
    ((!$past(test_voltage_level, 3) || !$past(mode_strap_pin, 3)) ? MODE_USER :
    ($past(eprom_variant, 3) ? MODE_BOOTSTRAP : MODE_SELFCHECK)))
    else $error("latched mode disagrees with pins");
  a_mode_held: assert property (mode_valid && $past(mode_valid) |-> $stable(op_mode))
    else $error("mode moved after latch");
  a_valid_after: assert property ($rose(resetn) |=> mode_valid)
    else $error("mode not latched after release");
  a_strap_free: assert property ($rose(resetn) |=> strap_released && !$past(strap_released))
    else $error("strap release differs from latch");
  a_start_addr: assert property (mode_valid |-> cpu_start_addr ==
    (op_mode == MODE_USER ? USER_START :
    (op_mode == MODE_SELFCHECK ? SELFCHECK_START : BOOT_START)))
    else $error("start address wrong for mode");
  // either the reset or the hold follows a low supply, chosen by the enable bit
  a_supply_seen: assert property (retention_hold == (!$past(low_voltage_reset_enable) &&
    $past(supply_low, 3)))
    else $error("low supply not reported");
  a_lvr_pick: assert property (low_voltage_reset == ($past(low_voltage_reset_enable) &&
    $past(supply_low, 3)))
    else $error("low-voltage reset disagrees with enable");
  a_we_range: assert property (eprom_we |-> eprom_addr >= EPROM_START && eprom_addr <= EPROM_END)
    else $error("programming outside user area");
  a_done_last: assert property ($rose(eprom_done) |-> eprom_we && eprom_addr == EPROM_END)
    else $error("done not on last byte");
  a_we_boot: assert property (eprom_we |-> op_mode == MODE_BOOTSTRAP && !$past(eprom_done))
    else $error("programming outside bootstrap");
  a_leds_self: assert property ($changed(status_leds) |-> op_mode == MODE_SELFCHECK)
    else $error("leds moved outside self-check");
endmodule : mode_select_props
bind mode_select_selfcheck mode_select_props #(.USER_START(USER_START), .BOOT_START(BOOT_START))
  u_props (.clk_sys, .resetn, .test_voltage_level, .mode_strap_pin, .supply_low, .eprom_variant,
  .status_leds, .op_mode, .mode_valid, .strap_released, .cpu_start_addr, .low_voltage_reset,
  .retention_hold, .eprom_addr, .eprom_we, .eprom_done, .low_voltage_reset_enable);
`default_nettype wire

/* File: bench/test_board.sv */
// Purpose: model of the outside test board that straps the mode pins
// Assumes: jumper levels and brownout are set by the bench per scenario
// Notes: once freed, the strap line carries port traffic toggling every cycle
`timescale 1ns/10ps
`default_nettype none
module test_board (
  input wire logic clk_sys,
  input wire logic want_test,
  input wire logic want_strap,
  input wire logic want_variant,
  input wire logic brownout,
  input wire logic strap_released,
  output logic test_voltage_level,
  output logic mode_strap_pin,
  output logic eprom_variant,
  output logic supply_low
);
  logic port_q = 1'b0;
  // port pattern never rests, so a latch that keeps listening is caught
  always @(posedge clk_sys) begin
    port_q <= ~port_q;
  end
  // jumpers hold the levels until the device frees the strap line
  assign test_voltage_level = want_test;
  assign mode_strap_pin = strap_released ? port_q : want_strap;
  assign eprom_variant = want_variant;
  assign supply_low = brownout;
endmodule : test_board
`default_nettype wire

/* File: bench/mode_select_selfcheck_tb.sv */
// Purpose: self-checking bench for mode select and self-check
// Assumes: the test board model drives strap and supply pins
// Notes: driver queues expected reads; a falling-edge monitor matches them
`timescale 1ns/10ps
`default_nettype none
module mode_select_selfcheck_tb;
  import mode_select_pkg::*;
  logic clk_sys, resetn, want_test, want_strap, want_variant, brownout, pend;
  logic test_voltage_level, mode_strap_pin, supply_low, eprom_variant, strap_released, eprom_we;
  logic [7:0] reg_rdata, eprom_data;
  logic [15:0] eprom_addr, ent;
  reg_req_t reg_req;
  logic [15:0] rq[$];
  logic [23:0] eq[$];
  int n_fail, checks;
  logic [3:0] codes [8] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h8, 4'h7};
  logic [4:0] modes [6] = '{5'b00000, 5'b10000, 5'b01000, 5'b01100, 5'b11001, 5'b11110};
  mode_select_selfcheck u_dut (.clk_sys, .resetn, .test_voltage_level, .mode_strap_pin,
    .supply_low, .eprom_variant, .reg_req, .reg_rdata, .status_leds(), .op_mode(),
    .mode_valid(), .strap_released, .cpu_start_addr(), .low_voltage_reset_enable(),
    .low_voltage_reset(), .retention_hold(), .eprom_addr, .eprom_data, .eprom_we,
    .eprom_done());
  test_board u_board (.clk_sys, .want_test, .want_strap, .want_variant, .brownout,
    .strap_released, .test_voltage_level, .mode_strap_pin, .eprom_variant, .supply_low);
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // whole-struct requests, so back-to-back calls never drive both strobes at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rq.push_back({e, m});
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
  endtask : rd
  task automatic nop(input int n);
    reg_req <= '0;
    repeat (n) @(posedge clk_sys);
  endtask : nop
  // reset is held four edges so the pin synchronisers are full at release
  task automatic boot(input logic [2:0] pins);
    resetn <= 1'b0;
    reg_req <= '0;
    {want_test, want_strap, want_variant} <= pins;
    brownout <= 1'b1;
    @(posedge clk_sys);
    brownout <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
  endtask : boot
  // falling edge keeps clear of the rising-edge updates
  always @(negedge clk_sys) begin
    if (pend) begin
      ent = rq.pop_front();
      check("reg_rdata", {16'h0000, ent[15:8]}, {16'h0000, reg_rdata & ent[7:0]});
    end
    pend = reg_req.rd;
    if (eprom_we) begin
      check("eprom write", eq.size() != 0 ? eq.pop_front() : 'x, {eprom_addr, eprom_data});
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    logic [7:0] v;
    resetn = 1'b0;
    reg_req = '0;
    pend = 1'b0;
    brownout = 1'b0;
    {want_test, want_strap, want_variant} = 3'b000;
    void'($urandom(69156));
    // six of the eight pin combinations; later the strap toggles and the mode must hold
    foreach (modes[i]) begin
      boot(modes[i][4:2]);
      rd(MODE_STATUS_ADDR, {6'b000001, modes[i][1:0]}, 8'hFF);
      rd(MISC_CONTROL_ADDR, 8'h10, 8'hFF);
      nop(6);
      rd(MODE_STATUS_ADDR, {6'b000001, modes[i][1:0]}, 8'hFF);
    end
    boot(3'b000);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      v[3] = i[0];
      wr(MISC_CONTROL_ADDR, v);
      rd(MISC_CONTROL_ADDR, v, 8'hFF);
      rd(MODE_STATUS_ADDR, {4'h0, v[3], 3'b100}, 8'hFF);
    end
    rd(8'h20, 8'h00, 8'hFF);
    wr(BOOT_DATA_ADDR, 8'hA5);
    wr(CHECK_REPORT_ADDR, 8'h80);
    rd(CHECK_REPORT_ADDR, 8'h00, 8'h0F);
    // low supply with the reset function off freezes the registers
    wr(MISC_CONTROL_ADDR, 8'h00);
    brownout <= 1'b1;
    nop(5);
    wr(MISC_CONTROL_ADDR, 8'hFF);
    rd(MISC_CONTROL_ADDR, 8'h00, 8'hFF);
    rd(MODE_STATUS_ADDR, 8'h14, 8'hFF);
    brownout <= 1'b0;
    nop(5);
    wr(MISC_CONTROL_ADDR, 8'h08);
    brownout <= 1'b1;
    nop(5);
    rd(MODE_STATUS_ADDR, 8'h0C, 8'hFF);
    brownout <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      boot(3'b110);
      rd(CHECK_REPORT_ADDR, 8'h00, 8'h0F);
      wr(CHECK_REPORT_ADDR, 8'h80);
      rd(CHECK_REPORT_ADDR, 8'h0F, 8'h0F);
      wr(CHECK_REPORT_ADDR, 8'h80);
      rd(CHECK_REPORT_ADDR, 8'h00, 8'h0F);
      wr(CHECK_REPORT_ADDR, 8'hC0 | 8'(k));
      wr(CHECK_REPORT_ADDR, 8'h80);
      rd(CHECK_REPORT_ADDR, {4'h2, codes[k]}, 8'h3F);
    end
    boot(3'b111);
    rd(BOOT_DATA_ADDR, 8'h00, 8'h01);
    for (int i = 0; i < int'(EPROM_BYTES); i++) begin
      v = 8'($urandom());
      eq.push_back({EPROM_START + 16'(i), v});
      wr(BOOT_DATA_ADDR, v);
    end
    wr(BOOT_DATA_ADDR, 8'h3C);
    rd(BOOT_DATA_ADDR, 8'h01, 8'h01);
    nop(4);
    check("eprom queue", 24'h0, 24'(eq.size()));
    stop_test();
  end
endmodule : mode_select_selfcheck_tb
`default_nettype wire
